// File: rtl/adcsc_pkg.sv
// Shared constants and types for the converter serial link, both ends.
package adcsc_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_STD_NS = 400;
  localparam int ACQ_HI_NS = 600;
  localparam int ACQ_STD_CYC = (ACQ_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_HI_CYC = (ACQ_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_MS = 2;
  localparam int WAKE_CYC = WAKE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CONV_CYC = 150;
  localparam int SCLK_HALF_CYC = 8;
  localparam int GAP_CYC = 16;
  localparam int TRIG_LOW_CYC = 4;
  localparam int TMR_W = 8;
  localparam int DIV_W = 5;
  localparam int WK_W = 18;
  // Word widths
  localparam int CTRL_W = 6;
  localparam int CH_W = 3;
  localparam int RES_W = 12;
  localparam int WRITE_MIN_BITS = 6;
  localparam int BYTE_BITS = 8;
  localparam int READ_BITS = 16;
  // Control word fields and values
  localparam int CW_CODING = 5;
  localparam int CW_SLEEP = 4;
  localparam int CW_START = 3;
  localparam int CW_CH_LSB = 0;
  localparam logic [CTRL_W-1:0] CW_RESET = 6'h00;
  localparam logic [CTRL_W-1:0] SLEEP_MASK = 6'h10;
  localparam logic [RES_W-1:0] TWOS_FLIP = 12'h800;
  localparam logic RD_PAD = 1'b0;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [5:0] DEV_SYNC_INIT = 6'h2f;
  // Host register map
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_PIN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WORD_LSB = 8;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_CONV = 2'h3;
  localparam int ST_DONE = 1;

  typedef enum logic [1:0] {
    DV_TRACK = 2'b00,
    DV_CONV = 2'b01,
    DV_ACQ = 2'b10
  } adcsc_dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_XFER = 3'b001,
    H_GAP = 3'b010,
    H_TRIG = 3'b011,
    H_ARM = 3'b100,
    H_WAIT = 3'b101
  } adcsc_host_state_e;
endpackage

// File: rtl/adcsc_link_if.sv
// Serial link pins between the converter and its host.
`timescale 1ns/1ns
interface adcsc_link_if;
  logic sclk;
  logic ser_in;
  logic ser_out;
  logic ser_out_oe;
  logic ser_out_line;
  logic tx_frame_n;
  logic rx_frame_n;
  logic conv_trigger_n;
  logic standby_n;
  logic eoc_n;

  // Undriven output line floats to the pulled-up idle level
  assign ser_out_line = ser_out_oe ? ser_out : adcsc_pkg::LINE_IDLE;

  modport device (
    input sclk, ser_in, tx_frame_n, rx_frame_n, conv_trigger_n, standby_n,
    output ser_out, ser_out_oe, eoc_n
  );
  modport host (
    output sclk, ser_in, tx_frame_n, rx_frame_n, conv_trigger_n, standby_n,
    input ser_out_line, eoc_n
  );
endinterface

// File: rtl/adcsc_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ns
module adcsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta <= INIT;
      o_sync <= INIT;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

// File: rtl/adcsc_device.sv
// Converter end: control word receiver, conversion timing, standby and result sender.
// Overview of operation
// - Conversion-start rising edge puts sampler into hold
// - Conversion end returns sampler to tracking
// - Acquisition time must pass before next hold
// - Standby when pin low or sleep bit set
// - Host waits wake-up time after a standby pin exit, not after a sleep-bit exit
// - Six-bit control word accepted, MSB first
// - Write frame: at least six bits, strobe low
// - One byte write, then strobe raised
// - Result read as sixteen bits per frame
// - Read may split in two bytes, strobe low
// - Both directions shift most significant bit first
// - Frame strobes are driven active low
// - Serial clock toggles only inside frames
// - End-of-conversion falls when result ready
// - Result straight binary or two's complement
// - Coding chosen by control word bit
`timescale 1ns/1ns
module adcsc_device #(
  parameter bit HI_RANGE = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  adcsc_link_if.device link,
  input wire logic [adcsc_pkg::RES_W-1:0] i_sample,
  output logic o_tracking,
  output logic o_standby,
  output logic [adcsc_pkg::CTRL_W-1:0] o_ctrl,
  output logic [adcsc_pkg::RES_W-1:0] o_result
);
  localparam int TW = adcsc_pkg::TMR_W;
  localparam int ACQ_CYC = HI_RANGE ? adcsc_pkg::ACQ_HI_CYC : adcsc_pkg::ACQ_STD_CYC;
  localparam logic [TW-1:0] CONV_LOAD = TW'(adcsc_pkg::CONV_CYC - 1);
  localparam logic [TW-1:0] ACQ_LOAD = TW'(ACQ_CYC - 1);
  localparam logic [2:0] WR_BITS = 3'(adcsc_pkg::WRITE_MIN_BITS);
  localparam int RB = adcsc_pkg::READ_BITS;

  logic s_sclk;
  logic s_din;
  logic s_tx_n;
  logic s_rx_n;
  logic s_trig_n;
  logic s_stby_n;
  logic prev_sclk;
  logic prev_tx_n;
  logic prev_rx_n;
  logic prev_trig_n;
  logic [adcsc_pkg::CTRL_W-1:0] wr_sh;
  logic [2:0] wr_cnt;
  adcsc_pkg::adcsc_dev_state_e state;
  adcsc_pkg::adcsc_dev_state_e next_state;
  logic [TW-1:0] tmr;
  logic [TW-1:0] next_tmr;
  logic [adcsc_pkg::RES_W-1:0] sample_q;
  logic [adcsc_pkg::CH_W-1:0] ch_q;
  logic [RB-1:0] rd_sh;

  adcsc_sync #(
    .W(6),
    .INIT(adcsc_pkg::DEV_SYNC_INIT)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({link.sclk, link.ser_in, link.tx_frame_n, link.rx_frame_n,
              link.conv_trigger_n, link.standby_n}),
    .o_sync({s_sclk, s_din, s_tx_n, s_rx_n, s_trig_n, s_stby_n})
  );

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_sclk <= 1'b1;
      prev_tx_n <= 1'b1;
      prev_rx_n <= 1'b1;
      prev_trig_n <= 1'b1;
    end else begin
      prev_sclk <= s_sclk;
      prev_tx_n <= s_tx_n;
      prev_rx_n <= s_rx_n;
      prev_trig_n <= s_trig_n;
    end
  end

  wire sclk_fall = prev_sclk & ~s_sclk;
  wire sclk_rise = ~prev_sclk & s_sclk;
  wire tx_end = s_tx_n & ~prev_tx_n;
  wire rx_start = ~s_rx_n & prev_rx_n;
  wire trig_rise = s_trig_n & ~prev_trig_n;
  wire standby = ~s_stby_n | o_ctrl[adcsc_pkg::CW_SLEEP];
  wire wr_take = wr_cnt < WR_BITS;
  wire word_load = tx_end & ~wr_take;
  wire [adcsc_pkg::CTRL_W-1:0] keep_ctrl = (o_ctrl & ~adcsc_pkg::SLEEP_MASK) |
                                           (wr_sh & adcsc_pkg::SLEEP_MASK);
  wire [adcsc_pkg::CTRL_W-1:0] next_ctrl = standby ? keep_ctrl : wr_sh;
  wire soft_go = word_load & wr_sh[adcsc_pkg::CW_START];
  // A software start converts the channel of the word that carries it
  wire [adcsc_pkg::CTRL_W-1:0] go_ctrl = word_load ? next_ctrl : o_ctrl;
  wire go = (trig_rise | soft_go) & ~standby & (state == adcsc_pkg::DV_TRACK);
  wire conv_done = (state == adcsc_pkg::DV_CONV) && (tmr == '0);
  // two's complement flips the sign bit
  wire [adcsc_pkg::RES_W-1:0] coded = sample_q ^
    (o_ctrl[adcsc_pkg::CW_CODING] ? adcsc_pkg::TWOS_FLIP : '0);
  wire [RB-1:0] rd_word = {adcsc_pkg::RD_PAD, ch_q, o_result};

  // first six bits form the word
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_sh <= adcsc_pkg::CW_RESET;
      wr_cnt <= 3'h0;
    end else if (!s_tx_n) begin
      if (sclk_fall && wr_take) begin
        wr_sh <= {wr_sh[adcsc_pkg::CTRL_W-2:0], s_din};
        wr_cnt <= wr_cnt + 3'h1;
      end
    end else begin
      wr_cnt <= 3'h0;
    end
  end

  // load only after six bits framed
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ctrl <= adcsc_pkg::CW_RESET;
    end else if (word_load) begin
      o_ctrl <= next_ctrl;
    end
  end

  // Starts arriving during acquisition are dropped rather than queued
  always_comb begin
    next_state = state;
    next_tmr = tmr;
    case (state)
      adcsc_pkg::DV_TRACK: begin
        if (go) begin
          next_state = adcsc_pkg::DV_CONV;
          next_tmr = CONV_LOAD;
        end
      end
      adcsc_pkg::DV_CONV: begin
        if (tmr == '0) begin
          next_state = adcsc_pkg::DV_ACQ;
          next_tmr = ACQ_LOAD;
        end else begin
          next_tmr = tmr - 1'b1;
        end
      end
      adcsc_pkg::DV_ACQ: begin
        if (tmr == '0) begin
          next_state = adcsc_pkg::DV_TRACK;
        end else begin
          next_tmr = tmr - 1'b1;
        end
      end
      default: begin
        next_state = adcsc_pkg::DV_TRACK;
        next_tmr = '0;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= adcsc_pkg::DV_TRACK;
      tmr <= '0;
      o_tracking <= 1'b1;
      o_standby <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      o_tracking <= next_state != adcsc_pkg::DV_CONV;
      o_standby <= standby;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sample_q <= '0;
      ch_q <= '0;
    end else if (go) begin
      sample_q <= i_sample;
      ch_q <= go_ctrl[adcsc_pkg::CW_CH_LSB +: adcsc_pkg::CH_W];
    end
  end

  // coding bit applied when result lands
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_result <= '0;
    end else if (conv_done) begin
      o_result <= coded;
    end
  end

  // falls at completion, rises on read or start
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      link.eoc_n <= 1'b1;
    end else if (conv_done) begin
      link.eoc_n <= 1'b0;
    end else if (rx_start || go) begin
      link.eoc_n <= 1'b1;
    end
  end

  // frame held low keeps the shift running into byte two
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rd_sh <= '0;
      link.ser_out <= 1'b0;
      link.ser_out_oe <= 1'b0;
    end else begin
      // drive only while read frame low
      link.ser_out_oe <= ~s_rx_n;
      if (rx_start) begin
        link.ser_out <= rd_word[RB-1];
        rd_sh <= {rd_word[RB-2:0], 1'b0};
      end else if (!s_rx_n && sclk_rise) begin
        // next bit on rising edge, MSB first
        link.ser_out <= rd_sh[RB-1];
        rd_sh <= {rd_sh[RB-2:0], 1'b0};
      end else if (s_rx_n) begin
        link.ser_out <= 1'b0;
      end
    end
  end
endmodule

// File: rtl/adcsc_host.sv
// Host end: AHB-Lite command registers driving the converter serial link.
`timescale 1ns/1ns
module adcsc_host #(
  parameter int WAKE_CYC = adcsc_pkg::WAKE_CYC,
  parameter bit HI_RANGE = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  adcsc_link_if.host link
);
  localparam int DW = adcsc_pkg::DIV_W;
  localparam int WW = adcsc_pkg::WK_W;
  localparam int ACQ_CYC = HI_RANGE ? adcsc_pkg::ACQ_HI_CYC : adcsc_pkg::ACQ_STD_CYC;
  localparam logic [DW-1:0] HALF_END = DW'(adcsc_pkg::SCLK_HALF_CYC - 1);
  localparam logic [DW-1:0] GAP_END = DW'(adcsc_pkg::GAP_CYC - 1);
  localparam logic [DW-1:0] TRIG_END = DW'(adcsc_pkg::TRIG_LOW_CYC - 1);
  localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_CYC);
  localparam logic [WW-1:0] ACQ_LOAD = WW'(ACQ_CYC);
  localparam logic [3:0] BYTE_LOAD = 4'(adcsc_pkg::BYTE_BITS);
  localparam int RB = adcsc_pkg::READ_BITS;

  logic s_dout;
  logic s_eoc_n;
  logic ap_wr;
  logic [7:0] ap_addr;
  logic [1:0] pend_op;
  logic [adcsc_pkg::CTRL_W-1:0] pend_word;
  logic pin_sleep;
  logic done;
  logic [WW-1:0] wake_cnt;
  logic [WW-1:0] acq_cnt;
  adcsc_pkg::adcsc_host_state_e state;
  logic [DW-1:0] div;
  logic [3:0] bits;
  logic second;
  logic [adcsc_pkg::BYTE_BITS-1:0] tx_sh;
  logic [RB-1:0] rx_sh;
  logic [RB-1:0] result;

  adcsc_sync #(
    .W(2),
    .INIT(2'h3)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async({link.ser_out_line, link.eoc_n}),
    .o_sync({s_dout, s_eoc_n})
  );

  wire ap_take = i_hsel & i_hready & i_htrans[1];
  wire idle = state == adcsc_pkg::H_IDLE;
  wire busy = ~idle | (pend_op != adcsc_pkg::OP_NONE);
  wire awake = ~pin_sleep & (wake_cnt == '0);
  wire [1:0] w_op = i_hwdata[adcsc_pkg::CMD_OP_LSB +: 2];
  wire wr_cmd = ap_wr & (ap_addr == adcsc_pkg::OFS_CMD) & ~busy;
  wire wr_pin = ap_wr & (ap_addr == adcsc_pkg::OFS_PIN);
  wire wr_stat = ap_wr & (ap_addr == adcsc_pkg::OFS_STATUS);
  wire conv_ok = awake & (acq_cnt == '0);
  wire tick = div == HALF_END;
  wire xfer_end = (state == adcsc_pkg::H_XFER) & tick & ~link.sclk & (bits == 4'h1);
  wire read_end = xfer_end & ~link.rx_frame_n & second;
  wire eoc_seen = (state == adcsc_pkg::H_WAIT) & ~s_eoc_n;
  wire set_done = eoc_seen | read_end | (xfer_end & ~link.tx_frame_n);
  wire [31:0] rd_cmd = {24'h0, 6'h00, pend_op};
  wire [31:0] rd_stat = {28'h0, ~s_eoc_n, awake, done, busy};
  wire [31:0] rdata =
    (i_haddr[7:0] == adcsc_pkg::OFS_CMD) ? rd_cmd :
    (i_haddr[7:0] == adcsc_pkg::OFS_PIN) ? {31'h0, pin_sleep} :
    (i_haddr[7:0] == adcsc_pkg::OFS_STATUS) ? rd_stat :
    (i_haddr[7:0] == adcsc_pkg::OFS_RESULT) ? {16'h0, result} : 32'h0;

  // Zero-wait slave; read data is registered in the address phase
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
      o_hrdata <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      ap_wr <= ap_take & i_hwrite;
      ap_addr <= i_haddr[7:0];
      o_hrdata <= (ap_take & ~i_hwrite) ? rdata : 32'h0;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      done <= 1'b0;
      pin_sleep <= 1'b0;
      wake_cnt <= '0;
      acq_cnt <= '0;
    end else begin
      done <= set_done | (done & ~(wr_stat & i_hwdata[adcsc_pkg::ST_DONE]));
      if (wr_pin) begin
        pin_sleep <= i_hwdata[0];
      end
      if (wr_pin && pin_sleep && !i_hwdata[0]) begin
        wake_cnt <= WAKE_LOAD;
      end else if (wake_cnt != '0) begin
        wake_cnt <= wake_cnt - 1'b1;
      end
      if (eoc_seen) begin
        acq_cnt <= ACQ_LOAD;
      end else if (acq_cnt != '0) begin
        acq_cnt <= acq_cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      link.standby_n <= 1'b1;
    end else begin
      link.standby_n <= ~pin_sleep;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state <= adcsc_pkg::H_IDLE;
      pend_op <= adcsc_pkg::OP_NONE;
      pend_word <= adcsc_pkg::CW_RESET;
      div <= '0;
      bits <= 4'h0;
      second <= 1'b0;
      tx_sh <= 8'h00;
      rx_sh <= '0;
      result <= '0;
      link.sclk <= 1'b1;
      link.ser_in <= 1'b0;
      link.tx_frame_n <= 1'b1;
      link.rx_frame_n <= 1'b1;
      link.conv_trigger_n <= 1'b1;
    end else begin
      if (wr_cmd) begin
        pend_op <= w_op;
        pend_word <= i_hwdata[adcsc_pkg::CMD_WORD_LSB +: adcsc_pkg::CTRL_W];
      end
      case (state)
        adcsc_pkg::H_IDLE: begin
          div <= '0;
          bits <= BYTE_LOAD;
          second <= 1'b0;
          case (pend_op)
            adcsc_pkg::OP_WRITE: begin
              // one byte, word in top six bits
              tx_sh <= {pend_word, 2'b00};
              link.ser_in <= pend_word[adcsc_pkg::CTRL_W-1];
              link.tx_frame_n <= 1'b0;
              pend_op <= adcsc_pkg::OP_NONE;
              state <= adcsc_pkg::H_XFER;
            end
            adcsc_pkg::OP_READ: begin
              link.rx_frame_n <= 1'b0;
              pend_op <= adcsc_pkg::OP_NONE;
              state <= adcsc_pkg::H_XFER;
            end
            adcsc_pkg::OP_CONV: begin
              if (pin_sleep) begin
                pend_op <= adcsc_pkg::OP_NONE;
              end else if (conv_ok) begin
                link.conv_trigger_n <= 1'b0;
                pend_op <= adcsc_pkg::OP_NONE;
                state <= adcsc_pkg::H_TRIG;
              end
            end
            default: begin
            end
          endcase
        end
        adcsc_pkg::H_XFER: begin
          // clock toggles only inside a frame
          div <= tick ? '0 : div + 1'b1;
          if (tick && link.sclk) begin
            // sample on falling edge, idle high
            link.sclk <= 1'b0;
            rx_sh <= {rx_sh[RB-2:0], s_dout};
          end else if (tick) begin
            link.sclk <= 1'b1;
            tx_sh <= {tx_sh[6:0], 1'b0};
            link.ser_in <= tx_sh[6];
            bits <= bits - 4'h1;
            if (xfer_end && !link.tx_frame_n) begin
              // strobe held low for all bits
              link.tx_frame_n <= 1'b1;
              state <= adcsc_pkg::H_IDLE;
            end else if (xfer_end && !second) begin
              state <= adcsc_pkg::H_GAP;
            end else if (xfer_end) begin
              link.rx_frame_n <= 1'b1;
              result <= rx_sh;
              state <= adcsc_pkg::H_IDLE;
            end
          end
        end
        adcsc_pkg::H_GAP: begin
          div <= (div == GAP_END) ? '0 : div + 1'b1;
          if (div == GAP_END) begin
            bits <= BYTE_LOAD;
            second <= 1'b1;
            state <= adcsc_pkg::H_XFER;
          end
        end
        adcsc_pkg::H_TRIG: begin
          div <= div + 1'b1;
          if (div == TRIG_END) begin
            link.conv_trigger_n <= 1'b1;
            state <= adcsc_pkg::H_ARM;
          end
        end
        adcsc_pkg::H_ARM: begin
          if (s_eoc_n) begin
            state <= adcsc_pkg::H_WAIT;
          end
        end
        adcsc_pkg::H_WAIT: begin
          if (!s_eoc_n) begin
            state <= adcsc_pkg::H_IDLE;
          end
        end
        default: begin
          state <= adcsc_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule

// File: tb/adcsc_link_chk.sv
// Link-level assertions between the host and converter ends.
`timescale 1ns/1ns
module adcsc_link_chk (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic sclk,
  input wire logic ser_out_oe,
  input wire logic tx_frame_n,
  input wire logic rx_frame_n,
  input wire logic conv_trigger_n,
  input wire logic eoc_n
);
  localparam int ACQ_CYC = adcsc_pkg::ACQ_STD_CYC;
  logic sclk_q;
  logic eoc_q;
  logic [4:0] tx_falls;
  logic [4:0] rx_falls;
  logic [7:0] acq_cnt;
  wire sclk_fall = sclk_q & ~sclk;
  wire eoc_fall = eoc_q & ~eoc_n;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // Falls per frame; cycles since conversion end, saturating so idle time reads as long
  always_ff @(posedge i_mclk) begin
    sclk_q <= i_sys_rst | sclk;
    eoc_q <= i_sys_rst | eoc_n;
    tx_falls <= (i_sys_rst | tx_frame_n) ? 5'h00 : tx_falls + {4'h0, sclk_fall};
    rx_falls <= (i_sys_rst | rx_frame_n) ? 5'h00 : rx_falls + {4'h0, sclk_fall};
    acq_cnt <= i_sys_rst ? 8'hff : eoc_fall ? 8'h00 : acq_cnt + {7'h0, acq_cnt != 8'hff};
  end

  a_out_release: assert property (rx_frame_n [*4] |-> !ser_out_oe)
    else $error("data out driven outside read frame");
  a_sclk_gated: assert property ($changed(sclk) |->
    !tx_frame_n || !rx_frame_n || !$past(tx_frame_n) || !$past(rx_frame_n))
    else $error("serial clock moved outside a frame");
  a_sclk_idle: assert property ((tx_frame_n && rx_frame_n) [*2] |-> sclk)
    else $error("serial clock not idle high");
  a_trig_pulse: assert property ($fell(conv_trigger_n) |->
    !conv_trigger_n [*4] ##1 conv_trigger_n)
    else $error("start pulse length wrong");
  a_eoc_after: assert property ($rose(conv_trigger_n) |-> ##[150:170] $fell(eoc_n))
    else $error("end of conversion late or missing");
  a_eoc_busy: assert property ($rose(conv_trigger_n) |-> ##8 eoc_n [*8])
    else $error("end of conversion during conversion");
  a_acq_guard: assert property ($rose(conv_trigger_n) |-> acq_cnt >= ACQ_CYC - 1)
    else $error("hold edge inside acquisition time");
  a_write_len: assert property ($rose(tx_frame_n) |-> tx_falls == 5'h08)
    else $error("write frame not eight clocks");
  a_read_len: assert property ($rose(rx_frame_n) |-> rx_falls == 5'h10)
    else $error("read frame not sixteen clocks");
  a_eoc_clear: assert property ($fell(rx_frame_n) |-> ##[1:6] eoc_n)
    else $error("end of conversion not cleared by read");
endmodule

// File: tb/adcsc_bench.sv
// Self-checking bench: AHB host end facing the converter end over the link.
`timescale 1ns/1ns
module adcsc_bench;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic hsel, hwrite, hresp, hready, rdy_s, sclk_q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdat_s, v;
  logic [11:0] i_sample, s, e, o_result;
  logic [5:0] w, o_ctrl;
  logic o_tracking, o_standby;
  logic [7:0] tx_sh;
  logic [15:0] rx_sh;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  adcsc_link_if link_if ();
  adcsc_host #(.WAKE_CYC(20)) adcsc_host_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .link(link_if.host));
  adcsc_device adcsc_device_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .link(link_if.device),
    .i_sample(i_sample), .o_tracking(o_tracking), .o_standby(o_standby), .o_ctrl(o_ctrl),
    .o_result(o_result));
  adcsc_link_chk adcsc_link_chk_i (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
    .sclk(link_if.sclk), .ser_out_oe(link_if.ser_out_oe), .tx_frame_n(link_if.tx_frame_n),
    .rx_frame_n(link_if.rx_frame_n), .conv_trigger_n(link_if.conv_trigger_n),
    .eoc_n(link_if.eoc_n));

  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  // Bus answer and wire bits captured at the edge, free of update races
  always_ff @(posedge i_mclk) begin
    rdy_s <= hready;
    rdat_s <= hrdata;
    sclk_q <= link_if.sclk;
    if (sclk_q && !link_if.sclk && !link_if.tx_frame_n) tx_sh <= {tx_sh[6:0], link_if.ser_in};
    if (sclk_q && !link_if.sclk && !link_if.rx_frame_n) rx_sh <= {rx_sh[14:0], link_if.ser_out_line};
    cyc <= cyc + 1;
  end

  // A hang counts as a mismatch and still reaches the verdict
  initial begin
    wait (cyc == 60000);
    n_fail++;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do begin @(posedge i_mclk); #1; end while (rdy_s !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge i_mclk); #1; end while (rdy_s !== 1'b1);
    rd = rdat_s;
  endtask

  // Commands are refused while busy, so wait on both sides of each one
  task automatic cmd(input logic [1:0] op, input logic [5:0] word);
    do bus(1'b0, adcsc_pkg::OFS_STATUS, 32'h0, v); while (v[0] !== 1'b0);
    bus(1'b1, adcsc_pkg::OFS_CMD, {18'h00000, word, 6'h00, op}, v);
    do bus(1'b0, adcsc_pkg::OFS_STATUS, 32'h0, v); while (v[0] !== 1'b0);
    repeat (5) @(posedge i_mclk);
    #1;
  endtask

  function automatic logic [11:0] coded(input logic [11:0] x, input logic twos);
    return twos ? x ^ adcsc_pkg::TWOS_FLIP : x;
  endfunction

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, i_sample} = '0;
    hsize = 3'h2;
    void'($urandom(32'h01eb));
    repeat (5) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (5) @(posedge i_mclk);
    #1;
    chk({o_tracking, o_standby, link_if.eoc_n, o_ctrl}, {3'h5, adcsc_pkg::CW_RESET});
    for (int i = 0; i < 6; i++) begin
      w = {i[0], 2'b00, 3'($urandom)};
      s = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : (i == 2) ? 12'h800 : 12'($urandom);
      i_sample <= s;
      cmd(adcsc_pkg::OP_WRITE, w);
      chk(o_ctrl, w);
      chk(tx_sh[7:2], w);
      bus(1'b1, adcsc_pkg::OFS_CMD, {30'h0, adcsc_pkg::OP_CONV}, v);
      @(posedge link_if.conv_trigger_n);
      repeat (10) @(posedge i_mclk);
      i_sample <= ~s;
      #1;
      chk(o_tracking, 1'b0);
      cmd(adcsc_pkg::OP_NONE, 6'h00);
      e = coded(s, w[5]);
      chk({o_tracking, link_if.eoc_n, o_result}, {2'b10, e});
      cmd(adcsc_pkg::OP_READ, 6'h00);
      bus(1'b0, adcsc_pkg::OFS_RESULT, 32'h0, v);
      chk(v, {16'h0000, 1'b0, w[2:0], e});
      chk(rx_sh, {1'b0, w[2:0], e});
    end
    // Software start: the channel of the starting word travels with the result
    s = 12'($urandom);
    i_sample <= s;
    cmd(adcsc_pkg::OP_WRITE, 6'h0d);
    @(negedge link_if.eoc_n);
    repeat (2) @(posedge i_mclk);
    #1;
    chk({o_tracking, o_result}, {1'b1, s});
    cmd(adcsc_pkg::OP_READ, 6'h00);
    chk(rx_sh, {4'h5, s});
    cmd(adcsc_pkg::OP_WRITE, w | adcsc_pkg::SLEEP_MASK);
    chk({o_standby, o_ctrl}, {1'b1, w | adcsc_pkg::SLEEP_MASK});
    cmd(adcsc_pkg::OP_WRITE, 6'h3f);
    chk({o_standby, o_ctrl}, {1'b1, w | adcsc_pkg::SLEEP_MASK});
    cmd(adcsc_pkg::OP_WRITE, 6'h27);
    chk({o_standby, o_ctrl}, {1'b0, w});
    bus(1'b1, adcsc_pkg::OFS_PIN, 32'h1, v);
    repeat (6) @(posedge i_mclk);
    #1;
    chk(o_standby, 1'b1);
    bus(1'b1, adcsc_pkg::OFS_PIN, 32'h0, v);
    t0 = cyc;
    do bus(1'b0, adcsc_pkg::OFS_STATUS, 32'h0, v); while (v[2] !== 1'b1);
    chk(cyc - t0 >= 20, 1'b1);
    chk({hresp, o_standby}, 2'b00);
    report_and_stop();
  end
endmodule
